// *** hdl/fkm_pkg.sv ***
// Package for the flash key and margin command block
package fkm_pkg;
  // Register byte offsets
  localparam logic [7:0] FKM_OFS_CTRL = 8'h00;
  localparam logic [7:0] FKM_OFS_STATUS = 8'h04;
  localparam logic [7:0] FKM_OFS_INDEX = 8'h08;
  localparam logic [7:0] FKM_OFS_SLOT0 = 8'h10;
  localparam logic [7:0] FKM_OFS_SLOT5 = 8'h24;
  localparam logic [7:0] FKM_OFS_SECURITY = 8'h28;
  localparam logic [7:0] FKM_OFS_KEY0 = 8'h30;
  localparam logic [7:0] FKM_OFS_KEY3 = 8'h3C;
  localparam logic [7:0] FKM_OFS_MARGIN = 8'h40;
  // Status bit positions
  localparam int FKM_ST_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int FKM_ST_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int FKM_ST_PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int FKM_ST_MG1_BIT = 1;
  localparam int FKM_ST_MG0_BIT = 0;
  // Security register fields
  localparam int FKM_SEC_KEY_ACCESS_ENABLE_LSB = 6;
  localparam int FKM_SEC_SECURED_BIT = 0;
  localparam logic [1:0] FKM_KEY_ACCESS_ENABLE_ON = 2'h2;
  localparam logic [7:0] FKM_SEC_RESET = 8'h01;
  // Command codes
  localparam logic [7:0] FKM_CMD_KEY = 8'h0C;
  localparam logic [7:0] FKM_CMD_USER = 8'h0D;
  localparam logic [7:0] FKM_CMD_FIELD = 8'h0E;
  // Parameter index required at launch
  localparam logic [2:0] FKM_IDX_KEY = 3'h4;
  localparam logic [2:0] FKM_IDX_MARGIN = 3'h2;
  // Margin settings
  localparam logic [15:0] FKM_MRG_USER_MAX = 16'h0002;
  localparam logic [15:0] FKM_MRG_FIELD_MAX = 16'h0004;
  // Block address decode (upper address byte)
  localparam logic [7:0] FKM_PFLASH_HI_MIN = 8'hC0;
  localparam logic [7:0] FKM_EEPROM_HI = 8'h10;
  // Stored key reset values
  localparam logic [15:0] FKM_KEY_RESET = 16'hFFFF;
  typedef enum logic [1:0] {
    FKM_IDLE = 2'b00,
    FKM_EXEC = 2'b01,
    FKM_DONE = 2'b11
  } fkm_state_type;
endpackage : fkm_pkg

// *** hdl/fkm_flash_key_margin.sv ***
// Key-verification and read-margin command sequencer with APB registers
`timescale 1ns/1ps
`default_nettype none
module fkm_flash_key_margin
  import fkm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  output logic secured,
  output logic [2:0] pflash_margin,
  output logic [2:0] eeprom_margin,
  output logic command_complete_flag
);
  logic [15:0] slot_q [0:5];
  logic [15:0] key_q [0:3];
  logic [2:0] parameter_index_q;
  logic [7:0] security_config_reg_q;
  logic access_error_flag_q;
  logic command_complete_flag_q;
  logic mismatch_q;
  logic [2:0] pf_margin_q;
  logic [2:0] ee_margin_q;
  fkm_state_type state_q;
  logic wr_en;
  logic rd_en;
  logic launch;
  logic [7:0] cmd;
  logic key_match;
  logic addr_pf;
  logic addr_ee;
  logic [1:0] key_access_enable;
  logic bad;
  logic [31:0] rd_d;
  logic [2:0] lvl;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Writing one to complete bit clears it and launches; ignored while busy
  assign launch = wr_en && paddr == FKM_OFS_STATUS && pwdata[FKM_ST_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_q
    && state_q == FKM_IDLE;
  // Command byte and upper block address share slot zero
  assign cmd = slot_q[0][15:8];
  assign key_access_enable = security_config_reg_q[FKM_SEC_KEY_ACCESS_ENABLE_LSB +: 2];
  assign key_match = slot_q[1] == key_q[0] && slot_q[2] == key_q[1]
    && slot_q[3] == key_q[2] && slot_q[4] == key_q[3];
  assign addr_pf = slot_q[0][7:0] >= FKM_PFLASH_HI_MIN;
  assign addr_ee = slot_q[0][7:0] == FKM_EEPROM_HI;
  assign lvl = slot_q[2][2:0];

  // Execute-cycle error check for the latched command
  always_comb begin
    bad = 1'b1;
    unique case (cmd)
      FKM_CMD_KEY: begin
        bad = parameter_index_q != FKM_IDX_KEY
          || key_access_enable != FKM_KEY_ACCESS_ENABLE_ON
          || mismatch_q || !key_match;
      end
      FKM_CMD_USER: begin
        bad = parameter_index_q != FKM_IDX_MARGIN || !(addr_pf || addr_ee)
          || slot_q[2] > FKM_MRG_USER_MAX;
      end
      FKM_CMD_FIELD: begin
        bad = parameter_index_q != FKM_IDX_MARGIN || !special_mode
          || !(addr_pf || addr_ee) || slot_q[2] > FKM_MRG_FIELD_MAX;
      end
      default: bad = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= FKM_IDLE;
    end else begin
      unique case (state_q)
        FKM_IDLE: if (launch) state_q <= FKM_EXEC;
        FKM_EXEC: state_q <= FKM_DONE;
        FKM_DONE: state_q <= FKM_IDLE;
      endcase
    end
  end

  // Complete flag drops at launch, rises once execution ends
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      command_complete_flag_q <= 1'b1;
    end else if (launch) begin
      command_complete_flag_q <= 1'b0;
    end else if (state_q == FKM_DONE) begin
      command_complete_flag_q <= 1'b1;
    end
  end

  // Error is set by the command; a write of one clears it, the set wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      access_error_flag_q <= 1'b0;
    end else if (state_q == FKM_EXEC && bad) begin
      access_error_flag_q <= 1'b1;
    end else if (launch) begin
      access_error_flag_q <= 1'b0;
    end else if (wr_en && paddr == FKM_OFS_STATUS && pwdata[FKM_ST_ACCESS_ERROR_FLAG_BIT]) begin
      access_error_flag_q <= 1'b0;
    end
  end

  // Mismatch memory survives until reset only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mismatch_q <= 1'b0;
    end else if (state_q == FKM_EXEC && cmd == FKM_CMD_KEY && parameter_index_q == FKM_IDX_KEY
      && key_access_enable == FKM_KEY_ACCESS_ENABLE_ON && !key_match) begin
      mismatch_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      security_config_reg_q <= FKM_SEC_RESET;
    end else if (state_q == FKM_EXEC && cmd == FKM_CMD_KEY && !bad) begin
      security_config_reg_q[FKM_SEC_SECURED_BIT] <= 1'b0;
    end else if (wr_en && paddr == FKM_OFS_SECURITY) begin
      security_config_reg_q[7:1] <= pwdata[7:1];
    end
  end

  // Flash-targeted margin steers both arrays; EEPROM-targeted only EEPROM
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pf_margin_q <= 3'h0;
      ee_margin_q <= 3'h0;
    end else if (state_q == FKM_EXEC && cmd != FKM_CMD_KEY && !bad) begin
      ee_margin_q <= lvl;
      if (addr_pf) begin
        pf_margin_q <= lvl;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      parameter_index_q <= 3'h0;
    end else if (wr_en && paddr == FKM_OFS_INDEX && command_complete_flag_q) begin
      parameter_index_q <= pwdata[2:0];
    end
  end

  // Parameter slots and stored key are loadable only while idle
  for (genvar i = 0; i < 6; i++) begin : g_slot
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        slot_q[i] <= 16'h0000;
      end else if (wr_en && command_complete_flag_q && paddr == FKM_OFS_SLOT0 + 8'(4 * i)) begin
        slot_q[i] <= pwdata[15:0];
      end
    end
  end
  for (genvar k = 0; k < 4; k++) begin : g_key
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        key_q[k] <= FKM_KEY_RESET;
      end else if (wr_en && command_complete_flag_q && paddr == FKM_OFS_KEY0 + 8'(4 * k)) begin
        key_q[k] <= pwdata[15:0];
      end
    end
  end

  // Read mux; unmapped addresses and the key words read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (paddr == FKM_OFS_STATUS) begin
      rd_d[FKM_ST_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag_q;
      rd_d[FKM_ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
    end else if (paddr == FKM_OFS_INDEX) begin
      rd_d[2:0] = parameter_index_q;
    end else if (paddr == FKM_OFS_SECURITY) begin
      rd_d[7:0] = security_config_reg_q;
    end else if (paddr == FKM_OFS_MARGIN) begin
      rd_d[2:0] = pf_margin_q;
      rd_d[10:8] = ee_margin_q;
    end else if (paddr >= FKM_OFS_SLOT0 && paddr <= FKM_OFS_SLOT5 && paddr[1:0] == 2'h0) begin
      rd_d[15:0] = slot_q[3'((paddr - FKM_OFS_SLOT0) >> 2)];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  assign secured = security_config_reg_q[FKM_SEC_SECURED_BIT];
  assign pflash_margin = pf_margin_q;
  assign eeprom_margin = ee_margin_q;
  assign command_complete_flag = command_complete_flag_q;

  // Launch-cycle checks, plus security-release, mismatch-memory and flash-margin invariants
  a_key_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(secured) |-> !mismatch_q && $past(state_q) == FKM_EXEC && !access_error_flag_q)
    else $error("security released without good key");
  a_mismatch_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mismatch_q |=> mismatch_q)
    else $error("mismatch memory lost");
  a_blocked_key: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (launch && cmd == FKM_CMD_KEY && mismatch_q) |-> ##1 1'b1 ##1 access_error_flag_q)
    else $error("key attempt after mismatch not aborted");
  a_key_access_enable_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (launch && cmd == FKM_CMD_KEY && key_access_enable != FKM_KEY_ACCESS_ENABLE_ON)
    |-> ##2 access_error_flag_q && secured)
    else $error("key command ran while disabled");
  a_key_index: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (launch && cmd == FKM_CMD_KEY && parameter_index_q != FKM_IDX_KEY)
    |-> ##2 access_error_flag_q)
    else $error("wrong index not flagged");
  a_complete_time: assert property (@(posedge ref_clk) disable iff (!reset_n)
    launch |=> !command_complete_flag ##2 command_complete_flag)
    else $error("complete flag not set three cycles after launch");
  a_user_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (launch && cmd == FKM_CMD_USER && slot_q[2] > FKM_MRG_USER_MAX)
    |-> ##2 access_error_flag_q && $stable(ee_margin_q))
    else $error("bad user margin accepted");
  a_field_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (launch && cmd == FKM_CMD_FIELD && !special_mode) |-> ##2 access_error_flag_q)
    else $error("field margin outside special mode");
  a_ee_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $changed(pf_margin_q) |-> pf_margin_q == ee_margin_q)
    else $error("flash margin set without EEPROM");

  // Outcome checks anchored on the execute cycle, while slots and keys are frozen, then level, completion, freeze and status invariants
  a_key_words: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_KEY && parameter_index_q == FKM_IDX_KEY
    && key_access_enable == FKM_KEY_ACCESS_ENABLE_ON && !mismatch_q && slot_q[1] == key_q[0]
    && slot_q[2] == key_q[1] && slot_q[3] == key_q[2] && slot_q[4] == key_q[3])
    |=> !secured && !access_error_flag_q)
    else $error("matching key words did not release security");
  a_key_mismatch: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_KEY && parameter_index_q == FKM_IDX_KEY
    && key_access_enable == FKM_KEY_ACCESS_ENABLE_ON && slot_q[4] != key_q[3])
    |=> mismatch_q && access_error_flag_q && secured == $past(secured))
    else $error("key mismatch not remembered");
  a_secure_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mismatch_q && secured) |=> secured)
    else $error("security released after a mismatch");
  a_key_margin: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_KEY)
    |=> $stable(pf_margin_q) && $stable(ee_margin_q))
    else $error("key command touched margin levels");
  a_user_apply: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_USER && parameter_index_q == FKM_IDX_MARGIN
    && (slot_q[0][7:0] >= FKM_PFLASH_HI_MIN || slot_q[0][7:0] == FKM_EEPROM_HI)
    && slot_q[2] <= FKM_MRG_USER_MAX)
    |=> ee_margin_q == $past(lvl) && !access_error_flag_q)
    else $error("valid user margin not applied");
  a_field_apply: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_FIELD && special_mode
    && parameter_index_q == FKM_IDX_MARGIN && slot_q[0][7:0] == FKM_EEPROM_HI
    && slot_q[2] <= FKM_MRG_FIELD_MAX)
    |=> ee_margin_q == $past(lvl) && !access_error_flag_q)
    else $error("valid field margin not applied");
  a_field_pf: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_FIELD && special_mode
    && parameter_index_q == FKM_IDX_MARGIN && slot_q[0][7:0] >= FKM_PFLASH_HI_MIN
    && slot_q[2] <= FKM_MRG_FIELD_MAX)
    |=> pf_margin_q == $past(lvl) && ee_margin_q == $past(lvl))
    else $error("flash field margin not applied to both arrays");
  a_ee_target: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd != FKM_CMD_KEY && slot_q[0][7:0] == FKM_EEPROM_HI)
    |=> $stable(pf_margin_q))
    else $error("EEPROM-targeted margin changed flash reads");
  a_field_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && cmd == FKM_CMD_FIELD && slot_q[2] > FKM_MRG_FIELD_MAX)
    |=> access_error_flag_q && $stable(pf_margin_q) && $stable(ee_margin_q))
    else $error("bad field margin accepted");
  a_margin_index: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && (cmd == FKM_CMD_USER || cmd == FKM_CMD_FIELD)
    && parameter_index_q != FKM_IDX_MARGIN) |=> access_error_flag_q)
    else $error("wrong margin index not flagged");
  a_margin_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == FKM_EXEC && (cmd == FKM_CMD_USER || cmd == FKM_CMD_FIELD)
    && slot_q[0][7:0] < FKM_PFLASH_HI_MIN && slot_q[0][7:0] != FKM_EEPROM_HI)
    |=> access_error_flag_q)
    else $error("invalid block address not flagged");
  a_margin_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ee_margin_q <= FKM_MRG_FIELD_MAX && pf_margin_q <= FKM_MRG_FIELD_MAX)
    else $error("margin level outside defined settings");
  a_busy_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !command_complete_flag |-> state_q != FKM_IDLE)
    else $error("complete flag low while idle");
  a_complete_done: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_q == FKM_DONE |=> command_complete_flag && state_q == FKM_IDLE)
    else $error("command did not complete after execution");
  a_index_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !command_complete_flag |=> $stable(parameter_index_q))
    else $error("parameter index changed while busy");
  a_slots_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !command_complete_flag |=> $stable(slot_q[0]) && $stable(slot_q[2]))
    else $error("parameter slots changed while busy");
  a_status_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (psel && !penable && !pwrite && paddr == FKM_OFS_STATUS)
    |=> prdata[FKM_ST_PROTECTION_VIOLATION_FLAG_BIT] == 1'b0 && prdata[FKM_ST_MG1_BIT] == 1'b0
    && prdata[FKM_ST_MG0_BIT] == 1'b0)
    else $error("protection or verify flag reported");

  // Scenario covers
  c_key_ok: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(secured));
  c_field_set: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $changed(pf_margin_q) && pf_margin_q == 3'h4);
  c_ee_user: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $changed(ee_margin_q) && $stable(pf_margin_q));
  c_key_blocked: cover property (@(posedge ref_clk) disable iff (!reset_n)
    launch && cmd == FKM_CMD_KEY && mismatch_q);
  c_margin_error: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(access_error_flag_q) && cmd != FKM_CMD_KEY);
endmodule : fkm_flash_key_margin
`default_nettype wire

// *** test/fkm_apb_host.sv ***
// APB master standing in for CPU software on the flash command registers
`timescale 1ns/1ps
`default_nettype none
module fkm_apb_host (
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  output logic hung
);
  // Software runs from RAM, never from the block that holds the key
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hung <= 1'b1;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not keep showing the last value
    pwdata <= ~d;
  endtask : xfer
endmodule : fkm_apb_host
`default_nettype wire

// *** test/test_fkm_flash_key_margin.sv ***
// Self-checking bench for the flash key and margin command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin \
  checks_done++; \
  if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("ERROR at %0t: got %h expected %h", $time, act, exp); \
  end \
end
module test_fkm_flash_key_margin
  import fkm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic special_mode = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, secured, cc_flag, hung, ok, en;
  logic [7:0] paddr, hi;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pf, ee, exp_pf, exp_ee;
  logic [15:0] k [4];
  logic [15:0] p [4];
  logic [15:0] st;
  logic [7:0] cmd;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'hA0FB6129;
  always #5 ref_clk = ~ref_clk;
  fkm_apb_host u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .hung(hung));
  fkm_flash_key_margin DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_mode(special_mode), .secured(secured),
    .pflash_margin(pf), .eeprom_margin(ee), .command_complete_flag(cc_flag));
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  always @(posedge ref_clk) begin
    if (hung === 1'b1) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    exp_pf = 3'h0;
    exp_ee = 3'h0;
  endtask : do_reset
  // Loads the slots, launches, waits for completion and leaves status in rd
  task automatic run(input logic [7:0] c, input logic [7:0] h, input logic [2:0] idx);
    int n;
    wr(FKM_OFS_SLOT0, {16'h0000, c, h});
    for (int i = 0; i < 4; i++) wr(FKM_OFS_SLOT0 + 8'(4 * i + 4), {16'h0000, p[i]});
    wr(FKM_OFS_INDEX, {29'h0, idx});
    wr(FKM_OFS_STATUS, 32'h0000_0080);
    n = 0;
    do begin
      u_host.xfer(1'b0, FKM_OFS_STATUS, 32'h0000_0000, rd);
      n++;
    end while (rd[7] !== 1'b1 && n < 20);
    if (rd[7] !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    `CHK(cc_flag, 1'b1)
    `CHK(pslverr, 1'b0)
    `CHK({rd[4], rd[1:0]}, 3'b000)
  endtask : run
  function automatic logic margin_ok(logic [7:0] c, logic [7:0] h, logic [2:0] idx,
                                     logic [15:0] s, logic sm);
    logic good_addr;
    good_addr = (h >= FKM_PFLASH_HI_MIN) || (h == FKM_EEPROM_HI);
    if (idx != FKM_IDX_MARGIN || !good_addr) return 1'b0;
    if (c == FKM_CMD_USER) return s <= FKM_MRG_USER_MAX;
    return sm && (s <= FKM_MRG_FIELD_MAX);
  endfunction : margin_ok
  task automatic key_cmd(input logic [2:0] idx, input logic err, input logic sec);
    p = k;
    run(FKM_CMD_KEY, 8'h00, idx);
    `CHK(rd[5], err)
    `CHK(secured, sec)
  endtask : key_cmd
  initial begin
    do_reset();
    u_host.xfer(1'b0, FKM_OFS_SECURITY, 32'h0000_0000, rd);
    `CHK(rd[7:0], FKM_SEC_RESET)
    // Walk every setting of both commands first, then random cases
    for (int i = 0; i < 40; i++) begin
      cmd = (i < 12) ? ((i < 6) ? FKM_CMD_USER : FKM_CMD_FIELD)
        : 8'(FKM_CMD_USER + $unsigned($random(seed)) % 2);
      st = (i < 12) ? 16'(i % 6) : 16'($unsigned($random(seed)) % 6);
      case ($unsigned($random(seed)) % 3)
        0: hi = FKM_PFLASH_HI_MIN | 8'($random(seed));
        1: hi = FKM_EEPROM_HI;
        default: hi = 8'h20;
      endcase
      special_mode <= (i < 12) ? 1'b1 : 1'($random(seed));
      p = '{16'($random(seed)), st, 16'h0000, 16'h0000};
      run(cmd, hi, (i % 7 == 6) ? 3'h3 : FKM_IDX_MARGIN);
      ok = margin_ok(cmd, hi, (i % 7 == 6) ? 3'h3 : FKM_IDX_MARGIN, st, special_mode);
      if (ok) exp_ee = st[2:0];
      if (ok && hi >= FKM_PFLASH_HI_MIN) exp_pf = st[2:0];
      `CHK(rd[5], !ok)
      `CHK(pf, exp_pf)
      `CHK(ee, exp_ee)
      u_host.xfer(1'b0, FKM_OFS_MARGIN, 32'h0000_0000, rd);
      `CHK({rd[10:8], rd[2:0]}, {exp_ee, exp_pf})
    end
    // Field margins are left at normal once factory verify is done
    special_mode <= 1'b1;
    p = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    run(FKM_CMD_FIELD, FKM_PFLASH_HI_MIN, FKM_IDX_MARGIN);
    `CHK(rd[5], 1'b0)
    `CHK({pf, ee}, 6'h00)
    for (int i = 0; i < 4; i++) k[i] = 16'($random(seed));
    for (int i = 0; i < 4; i++) wr(FKM_OFS_KEY0 + 8'(4 * i), {16'h0000, k[i]});
    key_cmd(FKM_IDX_KEY, 1'b1, 1'b1);
    wr(FKM_OFS_SECURITY, 32'h0000_0080);
    u_host.xfer(1'b0, FKM_OFS_SECURITY, 32'h0000_0000, rd);
    en = (rd[7:6] === FKM_KEY_ACCESS_ENABLE_ON);
    // Key access can only be exercised where the enable field is writable
    if (en) begin
      key_cmd(3'h3, 1'b1, 1'b1);
      key_cmd(FKM_IDX_KEY, 1'b0, 1'b0);
      do_reset();
      for (int i = 0; i < 4; i++) wr(FKM_OFS_KEY0 + 8'(4 * i), {16'h0000, k[i]});
      wr(FKM_OFS_SECURITY, 32'h0000_0080);
      k[3] = k[3] ^ 16'h0001;
      key_cmd(FKM_IDX_KEY, 1'b1, 1'b1);
      k[3] = k[3] ^ 16'h0001;
      key_cmd(FKM_IDX_KEY, 1'b1, 1'b1);
    end
    stop_test();
  end
endmodule : test_fkm_flash_key_margin
`default_nettype wire
